// ==== srctl_regs.svh ====
// Timing counts and fixed values of the system reset controller.
`ifndef SRCTL_REGS_SVH
`define SRCTL_REGS_SVH
`define SRCTL_CLK_PERIOD_NS 10
`define SRCTL_POR_DELAY_MIN_MS 3
`define SRCTL_POR_DELAY_TYP_MS 10
`define SRCTL_POR_DELAY_MAX_MS 31
`define SRCTL_POR_CYCLES ((`SRCTL_POR_DELAY_TYP_MS * 1000000) / `SRCTL_CLK_PERIOD_NS)
`define SRCTL_RST_DELAY_US 50
`define SRCTL_RST_CYCLES ((`SRCTL_RST_DELAY_US * 1000) / `SRCTL_CLK_PERIOD_NS)
`define SRCTL_PIN_LOW_NS 15000
`define SRCTL_PIN_CYCLES ((`SRCTL_PIN_LOW_NS + `SRCTL_CLK_PERIOD_NS - 1) / `SRCTL_CLK_PERIOD_NS)
`define SRCTL_MCD_TYP_NS 625000
`define SRCTL_MCD_MAX_NS 1200000
`define SRCTL_MCD_CYCLES (`SRCTL_MCD_TYP_NS / `SRCTL_CLK_PERIOD_NS)
`define SRCTL_RESET_VECTOR 16'h0000
`define SRCTL_PORT_LATCH_RST 1'h1
`define SRCTL_CLKSEL_INTERNAL 2'h0
`define SRCTL_NCAUSE 8
`define SRCTL_C_POR 0
`define SRCTL_C_PIN 1
`define SRCTL_C_CMP 2
`define SRCTL_C_SW 3
`define SRCTL_C_SUP 4
`define SRCTL_C_WDT 5
`define SRCTL_C_MCD 6
`define SRCTL_C_FLASH 7
`endif

// ==== srctl_pkg.sv ====
// Types of the system reset controller.
package srctl_pkg;
  typedef enum logic [1:0] {
    SRCTL_ST_POR_WAIT = 2'b00,
    SRCTL_ST_HOLD = 2'b01,
    SRCTL_ST_RELEASE = 2'b10,
    SRCTL_ST_RUN = 2'b11
  } srctl_state_t;
  typedef logic [7:0] srctl_cause_t;
endpackage

// ==== srctl_top.sv ====
// System reset controller: gathers reset causes and sequences release.
`timescale 1ns/1ns
`include "srctl_regs.svh"
// Overview of operation
// - Reset halts core, disables interrupts and timers.
// - Registers reset; power-on-only bits keep value.
// - RAM contents untouched by any reset.
// - Port latches 1, open-drain, weak pull-ups.
// - Retention keeps port, converter, reference state.
// - Power and supply resets drive pin low.
// - Exit clears program counter, internal oscillator.
// - Watchdog enabled; first fetch at 0x0000.
// - Eight reset causes enter reset.
// - Power-on delay typically 10 ms, 3..31 ms.
// - Non-power-on release delay typically 50 us.
// - Pin low 15 us causes reset.
// - Missing clock reset within 1.2 ms.
// - Too-slow clock counts as missing.
module srctl_top #(
  parameter int POR_CYCLES = `SRCTL_POR_CYCLES,
  parameter int MCD_CYCLES = `SRCTL_MCD_CYCLES,
  parameter int RST_CYCLES = `SRCTL_RST_CYCLES,
  parameter int PIN_CYCLES = `SRCTL_PIN_CYCLES,
  parameter int CNT_W = 22
) (
  // Clock and power-on reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Reset causes and retention enable.
  input wire logic i_ext_reset_pin_n,
  input wire logic i_cmp_reset,
  input wire logic i_sw_reset,
  input wire logic i_supply_low,
  input wire logic i_wdt_expired,
  input wire logic i_flash_error,
  input wire logic i_sysclk_tick,
  input wire logic i_retain_en,
  // Values to retain across non-power-on resets.
  input wire logic [7:0] i_port_cfg,
  input wire logic [7:0] i_dac_state,
  input wire logic [3:0] i_vref_cfg,
  // Reset pin drive, enable low while driving.
  output logic o_ext_reset_pin_n_out,
  output logic o_ext_reset_pin_n_oe_n,
  // Controls to the rest of the chip.
  output logic o_sys_reset,
  output logic o_core_halt,
  output logic o_irq_timer_disable,
  output logic o_por_only_reset,
  output logic o_ram_reset,
  output logic o_port_latch,
  output logic o_port_open_drain,
  output logic o_port_weak_pullup,
  output logic [7:0] o_port_cfg,
  output logic [7:0] o_dac_state,
  output logic [3:0] o_vref_cfg,
  output logic [15:0] o_program_counter,
  output logic [1:0] o_clk_sel,
  output logic o_wdt_enable,
  output srctl_pkg::srctl_cause_t o_reset_cause
);
  import srctl_pkg::*;

  // ----------------------------------------------------------------
  // Cause detection
  // ----------------------------------------------------------------
  srctl_state_t state_r;
  logic [CNT_W-1:0] delay_r;
  logic [CNT_W-1:0] pin_cnt_r;
  logic [CNT_W-1:0] mcd_cnt_r;
  logic pin_rst_r;
  logic mcd_rst_r;
  logic por_r;
  logic sup_rst_r;
  logic any_cause;
  srctl_cause_t cause_now;

  // The pin must stay low a full 15 us before it counts; shorter glitches are ignored.
  // While the controller drives the pin low itself, the level says nothing about the outside and would
  // hold the controller in reset forever; the price is that an outside pulse then goes unrecorded.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_ext_reset_pin_n || !o_ext_reset_pin_n_oe_n) begin
      pin_cnt_r <= '0;
      pin_rst_r <= 1'b0;
    end else if (pin_cnt_r >= CNT_W'(PIN_CYCLES - 1)) begin
      pin_rst_r <= 1'b1;
    end else begin
      pin_cnt_r <= pin_cnt_r + 1'b1;
    end
  end

  // The system clock is observed as a tick; a gap longer than the window means the clock is missing or too slow.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_sysclk_tick || state_r != SRCTL_ST_RUN) begin
      mcd_cnt_r <= '0;
      mcd_rst_r <= 1'b0;
    end else if (mcd_cnt_r >= CNT_W'(MCD_CYCLES - 1)) begin
      mcd_rst_r <= 1'b1;
    end else begin
      mcd_cnt_r <= mcd_cnt_r + 1'b1;
    end
  end

  always_comb begin
    cause_now = '0;
    cause_now[`SRCTL_C_POR] = por_r;
    cause_now[`SRCTL_C_PIN] = pin_rst_r;
    cause_now[`SRCTL_C_CMP] = i_cmp_reset;
    cause_now[`SRCTL_C_SW] = i_sw_reset;
    cause_now[`SRCTL_C_SUP] = i_supply_low;
    cause_now[`SRCTL_C_WDT] = i_wdt_expired;
    cause_now[`SRCTL_C_MCD] = mcd_rst_r;
    cause_now[`SRCTL_C_FLASH] = i_flash_error;
  end
  assign any_cause = |cause_now;

  // ----------------------------------------------------------------
  // Release sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_r <= SRCTL_ST_POR_WAIT;
      delay_r <= '0;
      por_r <= 1'b1;
    end else begin
      case (state_r)
        SRCTL_ST_POR_WAIT: begin
          if (delay_r >= CNT_W'(POR_CYCLES - 1)) begin
            por_r <= 1'b0;
            delay_r <= '0;
            state_r <= SRCTL_ST_HOLD;
          end else begin
            delay_r <= delay_r + 1'b1;
          end
        end
        SRCTL_ST_HOLD: begin
          delay_r <= '0;
          if (!any_cause) begin
            state_r <= SRCTL_ST_RELEASE;
          end
        end
        SRCTL_ST_RELEASE: begin
          if (any_cause) begin
            delay_r <= '0;
            state_r <= SRCTL_ST_HOLD;
          end else if (delay_r >= CNT_W'(RST_CYCLES - 1)) begin
            state_r <= SRCTL_ST_RUN;
          end else begin
            delay_r <= delay_r + 1'b1;
          end
        end
        SRCTL_ST_RUN: begin
          if (any_cause) begin
            state_r <= SRCTL_ST_HOLD;
          end
        end
        default: state_r <= SRCTL_ST_HOLD;
      endcase
    end
  end

  // Remembers whether the pending reset came from power or supply, so the pin stays driven until exit.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sup_rst_r <= 1'b1;
    end else if (i_supply_low) begin
      sup_rst_r <= 1'b1;
    end else if (state_r == SRCTL_ST_RUN) begin
      sup_rst_r <= 1'b0;
    end
  end

  // Cause flags are sticky while in reset so software can read why it restarted.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_reset_cause <= 8'h01;
    end else if (state_r == SRCTL_ST_RUN && any_cause) begin
      o_reset_cause <= cause_now;
    end else if (state_r != SRCTL_ST_RUN) begin
      o_reset_cause <= o_reset_cause | cause_now;
    end
  end

  // ----------------------------------------------------------------
  // Retained state
  // ----------------------------------------------------------------
  // Retention is only honoured for non-power-on resets; a power-on reset always returns defaults.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_port_cfg <= 8'h00;
      o_dac_state <= 8'h00;
      o_vref_cfg <= 4'h0;
    end else if (state_r == SRCTL_ST_RUN && !any_cause) begin
      o_port_cfg <= i_port_cfg;
      o_dac_state <= i_dac_state;
      o_vref_cfg <= i_vref_cfg;
    end else if (state_r == SRCTL_ST_RUN && !i_retain_en) begin
      o_port_cfg <= 8'h00;
      o_dac_state <= 8'h00;
      o_vref_cfg <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_sys_reset = state_r != SRCTL_ST_RUN;
  assign o_core_halt = o_sys_reset;
  assign o_irq_timer_disable = o_sys_reset;
  assign o_por_only_reset = state_r == SRCTL_ST_POR_WAIT;
  assign o_ram_reset = 1'b0;
  assign o_port_latch = `SRCTL_PORT_LATCH_RST;
  assign o_port_open_drain = 1'b1;
  assign o_port_weak_pullup = 1'b1;
  assign o_ext_reset_pin_n_out = 1'b0;
  assign o_ext_reset_pin_n_oe_n = !(o_sys_reset && (por_r || sup_rst_r));
  assign o_program_counter = `SRCTL_RESET_VECTOR;
  assign o_clk_sel = `SRCTL_CLKSEL_INTERNAL;
  assign o_wdt_enable = 1'b1;

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  // Counts reset cycles with no cause pending; it only feeds the checks and drives no output.
  logic [CNT_W-1:0] quiet_r;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || any_cause || !o_sys_reset) begin
      quiet_r <= '0;
    end else begin
      quiet_r <= quiet_r + 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  halt_in_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_sys_reset |-> (o_core_halt && o_irq_timer_disable))
    else $error("core not halted in reset");
  pin_drive_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (por_r && o_sys_reset) |-> !o_ext_reset_pin_n_oe_n)
    else $error("reset pin not driven during power reset");
  pin_release_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !o_sys_reset |-> o_ext_reset_pin_n_oe_n)
    else $error("reset pin driven while running");
  por_exit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($fell(por_r)) |-> $past(delay_r) == CNT_W'(POR_CYCLES - 1))
    else $error("power-on delay wrong length");
  release_delay_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(state_r == SRCTL_ST_RUN) |-> $past(delay_r) == CNT_W'(RST_CYCLES - 1))
    else $error("release delay wrong length");
  cause_enters_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_r == SRCTL_ST_RUN && (i_sw_reset || i_wdt_expired)) |=> o_sys_reset)
    else $error("reset cause ignored");
  pin_filter_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(pin_rst_r) |-> $past(pin_cnt_r) == CNT_W'(PIN_CYCLES - 1))
    else $error("pin filter length wrong");
  mcd_fire_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(mcd_rst_r) |=> o_sys_reset)
    else $error("missing clock did not reset");
  hold_request_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (any_cause && state_r != SRCTL_ST_POR_WAIT) |=> state_r == SRCTL_ST_HOLD)
    else $error("request not held");
  exit_values_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(o_sys_reset) |-> (o_wdt_enable && o_program_counter == 16'h0000 && o_clk_sel == 2'h0))
    else $error("wrong exit state");
  // The checks below cover pin drive, retention, the release and power-on delays, the pin and clock filters and the cause flags.
  // They use the internal counters against the same delay parameters, so a wrong delay constant does not show up as a timing failure.
  supply_pin_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_supply_low |=> (o_sys_reset && !o_ext_reset_pin_n_oe_n))
    else $error("reset pin not driven for supply reset");
  pin_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!o_ext_reset_pin_n_oe_n && o_sys_reset) |=> (!o_ext_reset_pin_n_oe_n || !o_sys_reset))
    else $error("reset pin released before exit");
  por_defaults_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_por_only_reset |-> (o_port_cfg == 8'h00 && o_dac_state == 8'h00 && o_vref_cfg == 4'h0))
    else $error("retained state kept through power-on reset");
  retain_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (o_sys_reset && !o_por_only_reset) |=> ($stable(o_port_cfg) && $stable(o_dac_state) && $stable(o_vref_cfg)))
    else $error("retained state changed in reset");
  release_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(o_sys_reset) |-> quiet_r == CNT_W'(RST_CYCLES + 1))
    else $error("release delay not measured from last cause");
  release_early_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_r == SRCTL_ST_RELEASE && delay_r < CNT_W'(RST_CYCLES - 1)) |=> o_sys_reset)
    else $error("core released early");
  por_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (o_por_only_reset && delay_r < CNT_W'(POR_CYCLES - 1)) |=> (o_por_only_reset && o_sys_reset))
    else $error("power-on delay cut short");
  pin_short_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!pin_rst_r && pin_cnt_r < CNT_W'(PIN_CYCLES - 1)) |=> !pin_rst_r)
    else $error("short pin pulse caused reset");
  pin_enters_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (pin_rst_r && state_r == SRCTL_ST_RUN) |=> o_sys_reset)
    else $error("pin reset ignored");
  mcd_slow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_r == SRCTL_ST_RUN && !i_sysclk_tick && mcd_cnt_r >= CNT_W'(MCD_CYCLES - 1)) |=> mcd_rst_r)
    else $error("slow clock not treated as missing");
  cause_sticky_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (o_sys_reset && $past(o_sys_reset)) |-> ((o_reset_cause & $past(o_reset_cause)) == $past(o_reset_cause)))
    else $error("reset cause flag lost in reset");
  hold_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_r == SRCTL_ST_HOLD) |=> (delay_r == '0))
    else $error("release delay not restarted");
  exit_clock_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(o_sys_reset) |-> (o_clk_sel == `SRCTL_CLKSEL_INTERNAL && o_program_counter == `SRCTL_RESET_VECTOR))
    else $error("wrong clock or start address on exit");
endmodule

// ==== srctl_pin_drv.sv ====
// Model of the external driver on the active-low reset pin.
`timescale 1ns/1ns
module srctl_pin_drv (
  // Clock.
  input wire logic i_core_clk,
  // Pin drive; when released, the pull-up brings the pin high.
  output logic o_pin_n
);
  initial o_pin_n = 1'h1;
  task automatic pulse(input int n);
    @(posedge i_core_clk);
    o_pin_n <= 1'h0;
    repeat (n) @(posedge i_core_clk);
    o_pin_n <= 1'h1;
  endtask
endmodule

// ==== tb.sv ====
// Self-checking testbench of the system reset controller.
`timescale 1ns/1ns
module tb;
  import srctl_pkg::*;
  localparam int POR = 20, RST = 10, PIN = 5, MCD = 30;
  logic clk, rst_n, cmp, sw, sup, wdt, fl, tick, tick_en, ret, drv_n;
  logic pin_out, oe_n, sys, halt, irqd, poro, ram, latch, od, pu, wdten;
  logic [7:0] pcfg, dac, opc, odac;
  logic [3:0] vref, ovr;
  logic [15:0] pc;
  logic [1:0] csel;
  srctl_cause_t cause;
  int err_count, n_tests, n;
  // The pin is a wired AND of both drivers and the pull-up.
  wire pin_n = drv_n & (oe_n | pin_out);
  srctl_pin_drv u_drv (.i_core_clk(clk), .o_pin_n(drv_n));
  srctl_top #(.POR_CYCLES(POR), .MCD_CYCLES(MCD), .RST_CYCLES(RST), .PIN_CYCLES(PIN)) u_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ext_reset_pin_n(pin_n), .i_cmp_reset(cmp),
    .i_sw_reset(sw), .i_supply_low(sup), .i_wdt_expired(wdt), .i_flash_error(fl),
    .i_sysclk_tick(tick), .i_retain_en(ret), .i_port_cfg(pcfg), .i_dac_state(dac),
    .i_vref_cfg(vref), .o_ext_reset_pin_n_out(pin_out), .o_ext_reset_pin_n_oe_n(oe_n),
    .o_sys_reset(sys), .o_core_halt(halt), .o_irq_timer_disable(irqd), .o_por_only_reset(poro),
    .o_ram_reset(ram), .o_port_latch(latch), .o_port_open_drain(od), .o_port_weak_pullup(pu),
    .o_port_cfg(opc), .o_dac_state(odac), .o_vref_cfg(ovr), .o_program_counter(pc),
    .o_clk_sel(csel), .o_wdt_enable(wdten), .o_reset_cause(cause));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tick <= rst_n ? (tick_en & ~tick) : 1'h0;
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts cycles until the core runs; a hang ends the run as a failure.
  task automatic wait_run(output int k);
    k = 0;
    while (sys !== 1'h0) begin
      @(negedge clk);
      k++;
      if (k > 300) begin
        err_count++;
        tally_and_finish;
      end
    end
  endtask
  task automatic after_exit;
    check(pc, 16'h0000); // Start vector.
    check(16'({csel, wdten, oe_n, ram, halt, irqd}), 16'h18); // Exit state.
    check(16'({latch, od, pu}), 16'h7); // Port defaults.
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic cause_case(input int idx);
    @(posedge clk);
    case (idx)
      2: cmp <= 1'h1;
      3: sw <= 1'h1;
      4: sup <= 1'h1;
      5: wdt <= 1'h1;
      default: fl <= 1'h1;
    endcase
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(16'({sys, halt, irqd, poro}), 16'hE); // Held in reset.
    check(16'(cause[idx]), 16'h1);
    check(16'(oe_n), 16'((idx == 4) ? 0 : 1));
    @(posedge clk);
    {cmp, sw, sup, wdt, fl} <= 5'h00;
    wait_run(n);
    check(16'(n >= RST && n <= RST + 4), 16'h1);
    after_exit;
  endtask
  task automatic pin_case;
    u_drv.pulse(PIN - 1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(16'(sys), 16'h0); // A short pulse is ignored.
    u_drv.pulse(PIN + 1);
    @(negedge clk);
    check(16'({sys, cause[1]}), 16'h3);
    wait_run(n);
    check(16'(n >= RST && n <= RST + 4), 16'h1);
    after_exit;
  endtask
  task automatic mcd_case;
    @(posedge clk);
    tick_en <= 1'h0;
    wait_run(n);
    n = 0;
    while (sys !== 1'h1 && n < MCD + 20) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= MCD - 2 && n < MCD + 20), 16'h1);
    check(16'(cause[6]), 16'h1);
    @(posedge clk);
    tick_en <= 1'h1;
    wait_run(n);
    after_exit;
  endtask
  task automatic ret_case(input logic keep);
    @(posedge clk);
    {ret, pcfg, dac, vref} <= {keep, 8'hA5, 8'h3C, 4'h9};
    repeat (3) @(posedge clk);
    sw <= 1'h1;
    repeat (2) @(posedge clk);
    {sw, pcfg, dac, vref} <= {1'h0, 8'h5A, 8'hC3, 4'h6};
    wait_run(n);
    check(16'({ovr, opc}), keep ? 16'h09A5 : 16'h0000);
    check(16'(odac), keep ? 16'h003C : 16'h0000);
  endtask
  // A power-on reset in mid-run returns defaults even with retention on.
  task automatic por_case;
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(16'({sys, oe_n, poro}), 16'h5); // Pin driven low.
    check(16'(cause), 16'h01);
    @(posedge clk);
    rst_n <= 1'h1;
    wait_run(n);
    check(16'(n >= POR + RST && n <= POR + RST + 4), 16'h1);
    check(16'({ovr, opc}), 16'h0000);
    check(16'(odac), 16'h0000);
    after_exit;
  endtask
  initial begin
    {rst_n, cmp, sw, sup, wdt, fl, ret} = 7'h00;
    {pcfg, dac, vref} = 20'h00000;
    err_count = 0;
    n_tests = 0;
    tick_en = 1'h1;
    repeat (15) @(posedge clk);
    @(negedge clk);
    check(16'({sys, oe_n, poro}), 16'h5); // Pin driven low.
    check(16'(cause), 16'h01);
    @(posedge clk);
    rst_n <= 1'h1;
    wait_run(n);
    check(16'(n >= POR + RST && n <= POR + RST + 4), 16'h1);
    after_exit;
    for (int i = 2; i < 8; i++) begin
      if (i != 6) begin
        cause_case(i);
      end
    end
    pin_case;
    mcd_case;
    ret_case(1'h1);
    por_case;
    ret_case(1'h0);
    tally_and_finish;
  end
endmodule
